// >>> pcm_pkg.sv
// ==========================================================
// Pulse channel support package
package pcm_pkg;

   // ==========================================================
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_FB0 = 6'h00;
   localparam logic [5:0] IDX_SEQ0 = 6'h01;
   localparam logic [5:0] IDX_CTL0_SHORT = 6'h02;
   localparam logic [5:0] IDX_CTL0_LONG = 6'h04;
   localparam logic [5:0] IDX_FB1 = 6'h04;
   localparam logic [5:0] IDX_SEQ1 = 6'h05;
   localparam logic [5:0] IDX_CTL1_SHORT = 6'h06;
   localparam logic [5:0] IDX_CTL1_LONG = 6'h0a;
   localparam logic [5:0] IDX_CUR0 = 6'h10;
   localparam logic [5:0] IDX_CUR1 = 6'h11;
   localparam logic [5:0] IDX_CFG = 6'h20;
   localparam int ADDR_LSB = 2;

   // ==========================================================
   // Control byte bits
   localparam int CTL_RUN = 0;
   localparam int CTL_MANUAL = 1;
   localparam int CTL_LEVEL = 2;
   localparam int CTL_W = 3;
   localparam logic [2:0] CTL_RESET = 3'h0;

   // Feedback byte bits
   localparam int FB_ACTIVE = 0;
   localparam int FB_OUT_LEVEL = 1;
   localparam int FB_IN_LEVEL = 2;
   localparam int FB_RUN_ACK = 3;
   localparam int FB_FAULT = 4;

   // Configuration word fields
   localparam int CFG_MODE0_LSB = 0;
   localparam int CFG_GATE0 = 3;
   localparam int CFG_MODE1_LSB = 4;
   localparam int CFG_GATE1 = 7;
   localparam int CFG_LONG_IF = 8;
   localparam int CFG_PARALLEL = 9;
   localparam int CFG_ISO = 10;
   localparam int CFG_W = 11;
   localparam logic [10:0] CFG_RESET = 11'h000;

   // ==========================================================
   // Operating modes
   typedef enum logic [2:0] {
      MODE_PULSE_OUT = 3'b000,
      MODE_PULSE_TRAIN = 3'b001,
      MODE_ONOFF_DELAY = 3'b010,
      MODE_PWM = 3'b011,
      MODE_FREQ = 3'b100
   } pcm_mode_t;

   // ==========================================================
   // Timing
   localparam int CLK_MHZ = 250;
   localparam int SAMPLE_MAX_US = 40;
   localparam int REFRESH_US = 500;
   localparam int SAMPLE_MAX_CYC = SAMPLE_MAX_US * CLK_MHZ;
   localparam int REFRESH_CYC = REFRESH_US * CLK_MHZ;

   // ==========================================================
   // Current measurement
   localparam int SEQ_W = 4;
   localparam int SMP_W = 12;
   localparam int PER_W = 24;
   localparam int SMP_SHIFT = 7;
   localparam int SMP_PER_WIN = 128;
   localparam logic [13:0] SCALE_MUL = 14'h374c;
   localparam int SCALE_SHIFT = 10;
   localparam logic [15:0] CODE_MAX = 16'h7fff;
endpackage

// >>> pcm_pulse_channel.sv
`timescale 1ns/10ps

// ==========================================================
// One output channel
module pcm_channel
   import pcm_pkg::*;
#(
   parameter int SMP_CYC = SAMPLE_MAX_CYC,
   parameter int REF_CYC = REFRESH_CYC
)(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Control
   input wire logic runReq,
   input wire logic manualSel,
   input wire logic levelCmd,
   input wire pcm_mode_t mode,
   input wire logic gateUse,
   input wire logic parallelOn,
   input wire logic isoOn,
   input wire logic latchStrobe,
   // Pins
   input wire logic auxInputPin,
   output logic pulseOut,
   // Waveform generator
   input wire logic genLevel,
   input wire logic genDone,
   input wire logic genFault,
   input wire logic [PER_W-1:0] periodCycles,
   output logic seqStart,
   output logic seqAbort,
   // Current samples
   input wire logic [SMP_W-1:0] curSample,
   // Feedback
   output logic [7:0] fbStatus,
   output logic [SEQ_W-1:0] seqCount,
   output logic [15:0] curCode
);
   localparam logic [PER_W-1:0] SMP_MAX = PER_W'(SMP_CYC);
   localparam logic [16:0] REF_LAST = 17'(REF_CYC - 1);
   localparam logic [PER_W-1:0] ONE = 24'h000001;

   logic auxMeta_r, auxSync_r, auxPrev_r, runPrev_r;
   logic manual_r, block_r, active_r, fault_r, pin_r, pinPrev_r;
   logic [SEQ_W-1:0] seqCnt_r;
   logic [PER_W-1:0] smpCnt_r, spacing;
   logic [SMP_W+6:0] acc_r;
   logic [6:0] nSmp_r;
   logic [SMP_W-1:0] mean_r;
   logic [16:0] refCnt_r;
   logic [15:0] cur_r;
   logic runRise, gateRise, manualEnter, pulseMode, measuring;
   logic smpTick, present;
   logic [SMP_W+6:0] accSum;
   logic [25:0] product;
   logic [25:0] scaled;

   // Edge and mode decode
   assign runRise = runReq && !runPrev_r;
   assign gateRise = auxSync_r && !auxPrev_r;
   assign manualEnter = manualSel && !runReq && !manual_r;
   assign pulseMode = (mode == MODE_PULSE_OUT) ||
                      (mode == MODE_PULSE_TRAIN);
   assign measuring = active_r && !manual_r &&
      ((mode == MODE_PWM) || (mode == MODE_PULSE_TRAIN));

   // Start request to the generator
   always_comb
   begin
      seqStart = 1'b0;
      if (runReq && !manual_r && !manualSel)
      begin
         if (gateUse)
            seqStart = gateRise && !block_r;
         else
            seqStart = runRise && !active_r;
      end
   end

   // Abort of a running sequence
   assign seqAbort = active_r && (!runReq || manualEnter);

   // Aux input synchroniser and edge history
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         auxMeta_r <= 1'b0;
         auxSync_r <= 1'b0;
         auxPrev_r <= 1'b0;
         runPrev_r <= 1'b0;
         pinPrev_r <= 1'b0;
      end
      else
      begin
         auxMeta_r <= auxInputPin;
         auxSync_r <= auxMeta_r;
         auxPrev_r <= auxSync_r;
         runPrev_r <= runReq;
         pinPrev_r <= pin_r;
      end
   end

   // Manual override state and restart block
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         manual_r <= 1'b0;
         block_r <= 1'b0;
      end
      else
      begin
         if (!manualSel)
            manual_r <= 1'b0;
         else if (manualEnter)
            manual_r <= 1'b1;
         if (manualEnter)
            block_r <= 1'b1;
         else if (runRise)
            block_r <= 1'b0;
      end
   end

   // Output active flag
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         active_r <= 1'b0;
      else if (!runReq || manualEnter || manual_r)
         active_r <= 1'b0;
      else if (seqStart)
         active_r <= 1'b1;
      else if (genDone && (mode != MODE_PWM) && (mode != MODE_FREQ))
         active_r <= 1'b0;
   end

   // Pulse fault flag, set wins over clear
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         fault_r <= 1'b0;
      else if (genFault && active_r)
         fault_r <= 1'b1;
      else if (manualEnter || runRise)
         fault_r <= 1'b0;
   end

   // Output pin
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         pin_r <= 1'b0;
      else if (manual_r)
         pin_r <= levelCmd;
      else if (active_r)
         pin_r <= genLevel;
      else
         pin_r <= 1'b0;
   end

   // Completed sequence counter
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         seqCnt_r <= 4'h0;
      else if (!runReq)
         seqCnt_r <= 4'h0;
      else
      begin
         case (mode)
            MODE_PULSE_OUT, MODE_PULSE_TRAIN:
            begin
               if (genDone && active_r)
               begin
                  if (gateUse)
                     seqCnt_r <= seqCnt_r + 4'h1;
                  else
                     seqCnt_r <= 4'h1;
               end
            end
            MODE_ONOFF_DELAY:
            begin
               if (pin_r != pinPrev_r)
                  seqCnt_r <= seqCnt_r + 4'h1;
            end
            default:
               seqCnt_r <= seqCnt_r;
         endcase
      end
   end

   // Sample spacing: period/128, bounded by the longest spacing
   always_comb
   begin
      spacing = periodCycles >> SMP_SHIFT;
      if (spacing > SMP_MAX)
         spacing = SMP_MAX;
      if (spacing == '0)
         spacing = ONE;
   end

   assign smpTick = measuring && (smpCnt_r == '0);
   assign accSum = acc_r + (SMP_W+7)'(curSample);

   // Sample accumulation over one window of 128 samples
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         smpCnt_r <= '0;
         acc_r <= '0;
         nSmp_r <= 7'h00;
         mean_r <= '0;
      end
      else if (!measuring)
      begin
         smpCnt_r <= '0;
         acc_r <= '0;
         nSmp_r <= 7'h00;
         mean_r <= '0;
      end
      else if (smpTick)
      begin
         smpCnt_r <= spacing - ONE;
         nSmp_r <= nSmp_r + 7'h01;
         if (nSmp_r == 7'(SMP_PER_WIN - 1))
         begin
            mean_r <= accSum[SMP_W+6:SMP_SHIFT];
            acc_r <= '0;
         end
         else
            acc_r <= accSum;
      end
      else
         smpCnt_r <= smpCnt_r - ONE;
   end

   // Scaling to the analog code with clamp
   assign product = 26'(mean_r) * 26'(SCALE_MUL);
   assign scaled = parallelOn ? (product >> (SCALE_SHIFT + 1)) :
                   (product >> SCALE_SHIFT);

   // Refresh timer for non-isochronous operation
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         refCnt_r <= 17'h00000;
      else if (refCnt_r == REF_LAST)
         refCnt_r <= 17'h00000;
      else
         refCnt_r <= refCnt_r + 17'h00001;
   end

   assign present = isoOn ? latchStrobe : (refCnt_r == REF_LAST);

   // Presented current word, written whole in one edge
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         cur_r <= 16'h0000;
      else if (!measuring)
         cur_r <= 16'h0000;
      else if (present)
      begin
         if (scaled > 26'(CODE_MAX))
            cur_r <= CODE_MAX;
         else
            cur_r <= scaled[15:0];
      end
   end

   // Feedback outputs
   always_comb
   begin
      fbStatus = 8'h00;
      fbStatus[FB_ACTIVE] = active_r;
      fbStatus[FB_OUT_LEVEL] = pin_r;
      fbStatus[FB_IN_LEVEL] = auxSync_r;
      fbStatus[FB_RUN_ACK] = runReq;
      fbStatus[FB_FAULT] = fault_r;
   end
   assign seqCount = seqCnt_r;
   assign curCode = cur_r;
   assign pulseOut = pin_r;
endmodule // pcm_channel

// ==========================================================
// Two-channel top with AHB-Lite register slave
module pcm_pulse_channel
   import pcm_pkg::*;
#(
   parameter int SMP_CYC = SAMPLE_MAX_CYC,
   parameter int REF_CYC = REFRESH_CYC
)(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Pins
   input wire logic [1:0] auxInputPin,
   output logic [1:0] pulseOut,
   // Waveform generators
   input wire logic [1:0] genLevel,
   input wire logic [1:0] genDone,
   input wire logic [1:0] genFault,
   input wire logic [1:0][PER_W-1:0] periodCycles,
   output logic [1:0] seqStart,
   output logic [1:0] seqAbort,
   // Current samples and latch instant
   input wire logic [1:0][SMP_W-1:0] curSample,
   input wire logic latchStrobe
);
   logic [CTL_W-1:0] ctl_r [2];
   logic [CFG_W-1:0] cfg_r;
   logic [5:0] idx_r;
   logic dphRead_r, dphWrite_r, rdDone_r;
   logic [31:0] rdData_r;
   logic [31:0] rdMux;
   logic [1:0][7:0] fb;
   logic [1:0][SEQ_W-1:0] seq;
   logic [1:0][15:0] cur;
   logic accept, wrEn;

   // Address phase and data phase tracking
   assign accept = hsel && hready && htrans[1];
   assign wrEn = dphWrite_r && hready;

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         dphRead_r <= 1'b0;
         dphWrite_r <= 1'b0;
         rdDone_r <= 1'b0;
         idx_r <= 6'h00;
         rdData_r <= 32'h00000000;
      end
      else if (hready)
      begin
         dphRead_r <= accept && !hwrite;
         dphWrite_r <= accept && hwrite;
         rdDone_r <= 1'b0;
         if (accept)
            idx_r <= haddr[ADDR_LSB+5:ADDR_LSB];
      end
      else if (dphRead_r)
      begin
         rdDone_r <= 1'b1;
         rdData_r <= rdMux;
      end
   end

   // One wait state on reads, none on writes; always OKAY
   assign hreadyout = !dphRead_r || rdDone_r;
   assign hresp = 1'b0;
   assign hrdata = rdData_r;

   // Read decode; unmapped indices read zero
   always_comb
   begin
      rdMux = 32'h00000000;
      case (idx_r)
         IDX_FB0: rdMux[7:0] = fb[0];
         IDX_SEQ0: rdMux[SEQ_W-1:0] = seq[0];
         IDX_CTL0_SHORT: rdMux[CTL_W-1:0] = ctl_r[0];
         IDX_FB1: rdMux[7:0] = fb[1];
         IDX_SEQ1: rdMux[SEQ_W-1:0] = seq[1];
         IDX_CTL1_SHORT, IDX_CTL1_LONG: rdMux[CTL_W-1:0] = ctl_r[1];
         IDX_CUR0: rdMux[15:0] = cur[0];
         IDX_CUR1: rdMux[15:0] = cur[1];
         IDX_CFG: rdMux[CFG_W-1:0] = cfg_r;
         default: rdMux = 32'h00000000;
      endcase
   end

   // Control bytes at the short or long interface location
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         ctl_r[0] <= CTL_RESET;
         ctl_r[1] <= CTL_RESET;
      end
      else if (wrEn)
      begin
         if (cfg_r[CFG_LONG_IF])
         begin
            if (idx_r == IDX_CTL0_LONG)
               ctl_r[0] <= hwdata[CTL_W-1:0];
            if (idx_r == IDX_CTL1_LONG)
               ctl_r[1] <= hwdata[CTL_W-1:0];
         end
         else
         begin
            if (idx_r == IDX_CTL0_SHORT)
               ctl_r[0] <= hwdata[CTL_W-1:0];
            if (idx_r == IDX_CTL1_SHORT)
               ctl_r[1] <= hwdata[CTL_W-1:0];
         end
      end
   end

   // Configuration word
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         cfg_r <= CFG_RESET;
      else if (wrEn && (idx_r == IDX_CFG))
         cfg_r <= hwdata[CFG_W-1:0];
   end

   // Channel instances
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++)
      begin : g_ch
         localparam int ML = (ch == 0) ? CFG_MODE0_LSB : CFG_MODE1_LSB;
         localparam int GB = (ch == 0) ? CFG_GATE0 : CFG_GATE1;
         pcm_channel #(
            .SMP_CYC(SMP_CYC),
            .REF_CYC(REF_CYC)
         ) u_ch (
            .sys_clk(sys_clk),
            .reset(reset),
            .runReq(ctl_r[ch][CTL_RUN]),
            .manualSel(ctl_r[ch][CTL_MANUAL]),
            .levelCmd(ctl_r[ch][CTL_LEVEL]),
            .mode(pcm_mode_t'(cfg_r[ML+2:ML])),
            .gateUse(cfg_r[GB]),
            .parallelOn(cfg_r[CFG_PARALLEL]),
            .isoOn(cfg_r[CFG_ISO]),
            .latchStrobe(latchStrobe),
            .auxInputPin(auxInputPin[ch]),
            .pulseOut(pulseOut[ch]),
            .genLevel(genLevel[ch]),
            .genDone(genDone[ch]),
            .genFault(genFault[ch]),
            .periodCycles(periodCycles[ch]),
            .seqStart(seqStart[ch]),
            .seqAbort(seqAbort[ch]),
            .curSample(curSample[ch]),
            .fbStatus(fb[ch]),
            .seqCount(seq[ch]),
            .curCode(cur[ch])
         );
      end
   endgenerate
endmodule // pcm_pulse_channel

// >>> pcm_tmp_unused_guard.sv
`timescale 1ns/10ps

// >>> pcm_pulse_channel_checker.sv
`timescale 1ns/10ps
// ==========================================================
// Bus and channel handshake checks
module pcm_pulse_channel_checker (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // Channel requests
   input wire logic [1:0] seqStart,
   input wire logic [1:0] seqAbort
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   logic rdAcc;
   logic wrAcc;
   // Accepted bus requests
   assign rdAcc = hsel && hready && htrans[1] && !hwrite;
   assign wrAcc = hsel && hready && htrans[1] && hwrite;

   // ==========================================================
   // Assertions
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("slave gave an error response");
   a_read_wait: assert property (rdAcc |=> !hreadyout ##1 hreadyout)
      else $error("read data phase not one wait state");
   a_write_nowait: assert property (wrAcc |=> hreadyout)
      else $error("write data phase stalled");
   a_wait_cause: assert property ($fell(hreadyout) |-> $past(rdAcc))
      else $error("wait state without a read");
   a_rdata_hold: assert property (
      hreadyout && $past(hreadyout) |-> $stable(hrdata))
      else $error("read data changed outside a read");
   a_start_once0: assert property (seqStart[0] |=> !seqStart[0])
      else $error("channel 0 start longer than one cycle");
   a_start_once1: assert property (seqStart[1] |=> !seqStart[1])
      else $error("channel 1 start longer than one cycle");
   a_start_abort: assert property ((seqStart & seqAbort) == 2'b00)
      else $error("start and abort together");

   // Main scenarios reached
   c_read: cover property (rdAcc);
   c_write: cover property (wrAcc);
   c_start: cover property (seqStart[0]);
   c_abort: cover property (seqAbort[0]);
endmodule // pcm_pulse_channel_checker

bind pcm_pulse_channel pcm_pulse_channel_checker pcm_pulse_channel_checker_i (
   .sys_clk, .reset, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
   .hrdata, .seqStart, .seqAbort);

// >>> pcm_gen_model.sv
`timescale 1ns/10ps
// ==========================================================
// Periodic waveform generator beside one channel
module pcm_gen_model #(
   parameter int LEN = 20
)(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Requests from the channel
   input wire logic seqStart,
   input wire logic seqAbort,
   // Generator outputs
   output logic genLevel,
   output logic genDone
);
   int cnt_r;
   logic run_r;
   // Runs from each start until aborted, repeating its period
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         run_r <= 1'b0;
         cnt_r <= 0;
      end
      else if (seqAbort)
         run_r <= 1'b0;
      else if (seqStart)
      begin
         run_r <= 1'b1;
         cnt_r <= 0;
      end
      else if (run_r)
         cnt_r <= (cnt_r == LEN - 1) ? 0 : cnt_r + 1;
   end
   // High for the first half, done on the last cycle
   assign genLevel = run_r && (cnt_r < LEN / 2);
   assign genDone = run_r && (cnt_r == LEN - 1);
endmodule // pcm_gen_model

// >>> testbench.sv
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench for the two-channel block
module testbench;
   import pcm_pkg::*;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout;
   logic [31:0] hrdata;
   logic [1:0] auxInputPin = 2'h0;
   logic [1:0] pulseOut;
   wire logic [1:0] genLevel;
   wire logic [1:0] genDone;
   logic [1:0] genFault = 2'h0;
   logic [1:0][PER_W-1:0] periodCycles = '0;
   logic [1:0] seqStart;
   logic [1:0] seqAbort;
   logic [1:0][SMP_W-1:0] curSample = '0;
   int mismatches = 0;
   int n_compared = 0;
   int i;
   logic [31:0] seed = 32'h39;
   logic [31:0] rd;
   logic [11:0] x;
   logic [31:0] ex;
   logic latchStrobe = 1'b0;

   // Clock
   always #2 sys_clk = ~sys_clk;

   // ==========================================================
   // Design and generator stand-ins
   pcm_pulse_channel #(.SMP_CYC(8), .REF_CYC(50)) pcm_pulse_channel_i (
      .sys_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .auxInputPin,
      .pulseOut, .genLevel, .genDone, .genFault, .periodCycles, .seqStart,
      .seqAbort, .curSample, .latchStrobe);
   pcm_gen_model #(.LEN(20)) gen0_i (.sys_clk, .reset,
      .seqStart(seqStart[0]), .seqAbort(seqAbort[0]),
      .genLevel(genLevel[0]), .genDone(genDone[0]));
   pcm_gen_model #(.LEN(20)) gen1_i (.sys_clk, .reset,
      .seqStart(seqStart[1]), .seqAbort(seqAbort[1]),
      .genLevel(genLevel[1]), .genDone(genDone[1]));

   // ==========================================================
   // Expectations and stimulus helpers
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [31:0] exp_code(input logic [11:0] ma,
      input logic par);
      logic [31:0] v;
      v = (32'(ma) * 32'(SCALE_MUL)) >> (SCALE_SHIFT + int'(par));
      return (v > 32'(CODE_MAX)) ? 32'(CODE_MAX) : v;
   endfunction

   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_pin(input logic got, input logic exp);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Waits for hready high at a rising edge, bounded
   task automatic wait_rdy();
      int n;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1)
      begin
         mismatches++;
         stop_test();
      end
   endtask

   // One single word transfer; read data lands in rd
   task automatic bus(input logic w, input logic [5:0] ix,
      input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      haddr <= {24'h0, ix, 2'h0};
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask

   task automatic wr(input logic [5:0] ix, input logic [31:0] d);
      bus(1'b1, ix, d);
   endtask

   task automatic rdchk(input logic [5:0] ix, input logic [31:0] m,
      input logic [31:0] exp);
      bus(1'b0, ix, 32'h0);
      chk_reg(rd & m, exp);
   endtask

   // Polls a feedback byte until a sequence has run and ended
   task automatic wait_seq(input logic [5:0] ix);
      int n;
      n = 0;
      rd = 32'h0;
      while (n < 300 && rd[0] !== 1'b1)
      begin
         bus(1'b0, ix, 32'h0);
         n++;
      end
      while (n < 600 && rd[0] !== 1'b0)
      begin
         bus(1'b0, ix, 32'h0);
         n++;
      end
      if (n >= 600)
      begin
         mismatches++;
         stop_test();
      end
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      rdchk(IDX_CFG, 32'hffffffff, 32'h0);
      rdchk(IDX_SEQ0, 32'hffffffff, 32'h0);
      wr(6'h0f, 32'hffffffff);
      rdchk(6'h0f, 32'hffffffff, 32'h0);
      // Ungated pulse output loads one, run low clears
      wr(IDX_CTL0_SHORT, 32'h1);
      wait_seq(IDX_FB0);
      rdchk(IDX_SEQ0, 32'hf, 32'h1);
      wr(IDX_CTL0_SHORT, 32'h0);
      rdchk(IDX_SEQ0, 32'hf, 32'h0);
      wr(IDX_CTL0_SHORT, 32'h1);
      wait_seq(IDX_FB0);
      rdchk(IDX_SEQ0, 32'hf, 32'h1);
      // Gated pulse train on channel 1, past the wrap
      wr(IDX_CFG, 32'h090);
      wr(IDX_CTL1_SHORT, 32'h1);
      for (i = 0; i < 17; i++)
      begin
         auxInputPin[1] <= 1'b1;
         wait_seq(IDX_FB1);
         auxInputPin[1] <= 1'b0;
         repeat (4) @(posedge sys_clk);
      end
      rdchk(IDX_SEQ1, 32'hf, 32'(17 % 16));
      auxInputPin[0] <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rdchk(IDX_FB0, 32'h4, 32'h4);
      auxInputPin[0] <= 1'b0;
      // On/off delay counts both pin edges
      wr(IDX_CFG, 32'h2);
      wr(IDX_CTL0_SHORT, 32'h0);
      wr(IDX_CTL0_SHORT, 32'h1);
      wait_seq(IDX_FB0);
      rdchk(IDX_SEQ0, 32'hf, 32'h2);
      // PWM current readings: rated, clamped, paralleled, random
      periodCycles[0] <= 24'd256;
      wr(IDX_CTL0_SHORT, 32'h0);
      for (i = 0; i < 5; i++)
      begin
         x = (i == 0) ? 12'd2000 : (i == 1) ? 12'hfff : 12'(xs());
         x = (i == 2) ? 12'd4000 : x;
         wr(IDX_CFG, (i == 2) ? 32'h203 : (i == 4) ? 32'h403 : 32'h3);
         curSample[0] <= x;
         wr(IDX_CTL0_SHORT, 32'h1);
         repeat (700) @(posedge sys_clk);
         // Isochronous: old word holds until the latch strobe
         if (i == 4)
         begin
            rdchk(IDX_CUR0, 32'hffffffff, ex);
            latchStrobe <= 1'b1;
            @(posedge sys_clk);
            latchStrobe <= 1'b0;
            repeat (2) @(posedge sys_clk);
         end
         ex = exp_code(x, i == 2);
         rdchk(IDX_CUR0, 32'hffffffff, ex);
      end
      rdchk(IDX_SEQ0, 32'hf, 32'h0);
      // Fault flag, then manual override of a running sequence
      genFault[0] <= 1'b1;
      @(posedge sys_clk);
      genFault[0] <= 1'b0;
      rdchk(IDX_FB0, 32'h11, 32'h11);
      wr(IDX_CTL0_SHORT, 32'h6);
      repeat (3) @(posedge sys_clk);
      chk_pin(pulseOut[0], 1'b1);
      rdchk(IDX_FB0, 32'h13, 32'h2);
      wr(IDX_CTL0_SHORT, 32'h2);
      repeat (3) @(posedge sys_clk);
      chk_pin(pulseOut[0], 1'b0);
      wr(IDX_CTL0_SHORT, 32'h6);
      repeat (3) @(posedge sys_clk);
      wr(IDX_CTL0_SHORT, 32'h0);
      repeat (3) @(posedge sys_clk);
      chk_pin(pulseOut[0], 1'b0);
      rdchk(IDX_FB0, 32'h1, 32'h0);
      repeat (100) @(posedge sys_clk);
      rdchk(IDX_CUR0, 32'hffff, 32'h0);
      // Frequency mode reports no current
      wr(IDX_CFG, 32'h040);
      curSample[1] <= 12'd2000;
      periodCycles[1] <= 24'd256;
      wr(IDX_CTL1_SHORT, 32'h0);
      wr(IDX_CTL1_SHORT, 32'h1);
      repeat (400) @(posedge sys_clk);
      rdchk(IDX_CUR1, 32'hffff, 32'h0);
      // Long control interface locations
      wr(IDX_CFG, 32'h140);
      wr(IDX_CTL0_SHORT, 32'h1);
      rdchk(IDX_FB0, 32'h8, 32'h0);
      wr(IDX_CTL0_LONG, 32'h1);
      rdchk(IDX_FB0, 32'h8, 32'h8);
      wr(IDX_CTL1_LONG, 32'h5);
      rdchk(IDX_CTL1_LONG, 32'h7, 32'h5);
      stop_test();
   end
endmodule // testbench
